// ### core/csa_pkg.sv
// Purpose: Shared constants and types for the control store access instruction block.
// Assumes: Instruction bit 0 is the most significant bit of the 32-bit word.
// Notes:   Contract list below; codes marked arbitrary are local encodings.
package csa_pkg;
  // Instruction field positions, bit 0 of the manual is bit 31 here.
  localparam int unsigned OPC_HI  = 31;
  localparam int unsigned OPC_LO  = 26;
  localparam int unsigned RD_HI   = 25;
  localparam int unsigned RD_LO   = 23;
  localparam int unsigned RS_HI   = 22;
  localparam int unsigned RS_LO   = 20;
  localparam int unsigned AUG_HI  = 19;
  localparam int unsigned AUG_LO  = 16;
  localparam int unsigned CHOP_HI = 22;
  localparam int unsigned CHOP_LO = 19;
  localparam int unsigned CON_HI  = 15;
  localparam int unsigned CON_LO  = 0;
  // Opcode values; jump and channel opcodes are arbitrary local codes.
  localparam logic [5:0] OPC_STORE = 6'h00;
  localparam logic [5:0] OPC_JUMP  = 6'h3e;
  localparam logic [5:0] OPC_CHAN  = 6'h3d;
  localparam logic [3:0] AUG_READ  = 4'hb;
  localparam logic [3:0] AUG_WRITE = 4'ha;
  // Store geometry.
  localparam int unsigned BANKS      = 2;
  localparam int unsigned BANK_DEPTH = 2048;
  localparam int unsigned BANK_AW    = 11;
  localparam int unsigned SA_W       = 12;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned ROW_W      = 64;
  localparam int unsigned ENTRY_W    = 6;
  localparam int unsigned CHA_W      = 16;
  localparam int unsigned MWA_HI     = 23;
  localparam int unsigned MWA_LO     = 2;
  localparam int unsigned MWA_W      = 22;
  localparam logic [31:0] LIM_TWO    = 32'h0000_0fff;
  localparam logic [31:0] LIM_ONE    = 32'h0000_07ff;
  // Condition code values, flag one is the top bit.
  localparam logic [3:0] CC_ERR  = 4'h8;
  localparam logic [3:0] CC_NONE = 4'h0;
  // Register map and fields.
  localparam int unsigned AXI_AW      = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STAT    = 8'h04;
  localparam logic [7:0]  REG_DONE    = 8'h08;
  localparam int unsigned CTRL_PRES   = 0;
  localparam int unsigned CTRL_TWO    = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h3;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_TRAP   = 1;
  localparam int unsigned STAT_ENT_LO = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_GET0 = 4'h1, S_GET1 = 4'h2, S_SWR  = 4'h3,
    S_SRD  = 4'h4, S_SLAT = 4'h5, S_PUT0 = 4'h6, S_PUT1 = 4'h7,
    S_UCOD = 4'h8, S_CHAN = 4'h9, S_FIN  = 4'ha
  } csa_state_e;

  // A store location is refused when the option is off or past the fitted modules.
  function automatic logic csa_store_bad(input logic pres, input logic two,
                                         input logic [31:0] a);
    csa_store_bad = !pres || (a > (two ? LIM_TWO : LIM_ONE));
  endfunction : csa_store_bad
endpackage : csa_pkg

// ### core/csa_store.sv
// Purpose: Writable microcode store built from two 2K by 64-bit banks.
// Assumes: One access per cycle; read data appears one edge after re.
// Notes:   Read data holds until the next read.
`timescale 1ns/10ps
module csa_store (
  // Clock
  input  wire logic                        aclk,
  // Access port
  input  wire logic                        we,
  input  wire logic                        re,
  input  wire logic [csa_pkg::SA_W-1:0]    addr,
  input  wire logic [csa_pkg::ROW_W-1:0]   wdata,
  output logic      [csa_pkg::ROW_W-1:0]   rdata
);
  logic [csa_pkg::ROW_W-1:0] bank_rd [csa_pkg::BANKS];
  logic                      sel_q;

  // Each bank decodes its own slice of the address.
  for (genvar b = 0; b < csa_pkg::BANKS; b++) begin : g_bank
    logic [csa_pkg::ROW_W-1:0] mem [csa_pkg::BANK_DEPTH];
    logic [csa_pkg::ROW_W-1:0] rd_q;
    wire hit = (addr[csa_pkg::SA_W-1] == 1'(b));
    always_ff @(posedge aclk) begin
      if (we && hit) begin
        mem[addr[csa_pkg::BANK_AW-1:0]] <= wdata;
      end
      if (re && hit) begin
        rd_q <= mem[addr[csa_pkg::BANK_AW-1:0]];
      end
    end
    assign bank_rd[b] = rd_q;
  end

  // Remember which bank answered so the output mux follows the read.
  always_ff @(posedge aclk) begin
    if (re) begin
      sel_q <= addr[csa_pkg::SA_W-1];
    end
  end

  assign rdata = bank_rd[sel_q];
endmodule : csa_store

// ### core/csa_axil.sv
// Purpose: AXI4-Lite slave with control, status and completion count registers.
// Assumes: 32-bit data, one outstanding write and one read.
// Notes:   Unmapped addresses answer SLVERR and read as zero.
`timescale 1ns/10ps
module csa_axil (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Write channels
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [csa_pkg::AXI_AW-1:0]    awaddr,
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic      [1:0]                    bresp,
  // Read channels
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [csa_pkg::AXI_AW-1:0]    araddr,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic      [31:0]                   rdata,
  output logic      [1:0]                    rresp,
  // Block side
  output logic      [1:0]                    ctrl,
  input  wire logic [31:0]                   stat,
  input  wire logic [31:0]                   count
);
  logic                       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [csa_pkg::AXI_AW-1:0] wa_q, wa_d;
  logic [31:0]                wd_q, wd_d, rd_q, rd_d;
  logic [1:0]                 ctrl_q, ctrl_d, br_q, br_d, rr_q, rr_d;
  logic                       wstrb_q0;

  function automatic logic mapped(input logic [csa_pkg::AXI_AW-1:0] a);
    if (a == csa_pkg::REG_CTRL) mapped = 1'b1;
    else if (a == csa_pkg::REG_STAT) mapped = 1'b1;
    else if (a == csa_pkg::REG_DONE) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction : mapped

  assign awready = !aw_q && !bv_q;
  assign wready  = !w_q && !bv_q;
  assign arready = !rv_q;

  // Address and data may arrive in either order; the response waits for both.
  always_comb begin
    aw_d = aw_q; w_d = w_q; wa_d = wa_q; wd_d = wd_q; bv_d = bv_q;
    br_d = br_q; ctrl_d = ctrl_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    if (awvalid && awready) begin aw_d = 1'b1; wa_d = awaddr; end
    if (wvalid && wready) begin w_d = 1'b1; wd_d = wdata; end
    if (aw_q && w_q) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1;
      br_d = mapped(wa_q) ? csa_pkg::RESP_OKAY : csa_pkg::RESP_SLVERR;
      if (wa_q == csa_pkg::REG_CTRL && wstrb_q0) begin
        ctrl_d = wd_q[1:0];
      end
    end
    if (bv_q && bready) bv_d = 1'b0;
    if (rv_q && rready) rv_d = 1'b0;
    if (arvalid && arready) begin
      rv_d = 1'b1;
      rr_d = mapped(araddr) ? csa_pkg::RESP_OKAY : csa_pkg::RESP_SLVERR;
      if (araddr == csa_pkg::REG_CTRL) rd_d = {30'h0, ctrl_q};
      else if (araddr == csa_pkg::REG_STAT) rd_d = stat;
      else if (araddr == csa_pkg::REG_DONE) rd_d = count;
      else rd_d = 32'h0;
    end
  end

  // Lane 0 strobe travels with the data so the write uses the strobe of its own beat.
  always_ff @(posedge aclk) begin
    if (!aresetn) wstrb_q0 <= 1'b0;
    else if (wvalid && wready) wstrb_q0 <= wstrb[0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      wa_q <= '0; wd_q <= '0; rd_q <= '0; br_q <= '0; rr_q <= '0;
      ctrl_q <= csa_pkg::CTRL_RST;
    end else begin
      aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
      wa_q <= wa_d; wd_q <= wd_d; rd_q <= rd_d; br_q <= br_d; rr_q <= rr_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign bvalid = bv_q;
  assign bresp  = br_q;
  assign rvalid = rv_q;
  assign rdata  = rd_q;
  assign rresp  = rr_q;
  assign ctrl   = ctrl_q;
endmodule : csa_axil

// ### core/csa_core.sv
// Purpose: Executes store write, store read, store jump and channel-form instructions.
// Assumes: Register data is valid in the cycle its selector is driven.
// Notes:   One instruction at a time; memory and store accesses never overlap.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module csa_core (
  // Clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // AXI4-Lite register bus
  input  wire logic                           s_awvalid,
  output logic                                s_awready,
  input  wire logic [csa_pkg::AXI_AW-1:0]     s_awaddr,
  input  wire logic                           s_wvalid,
  output logic                                s_wready,
  input  wire logic [31:0]                    s_wdata,
  input  wire logic [3:0]                     s_wstrb,
  output logic                                s_bvalid,
  input  wire logic                           s_bready,
  output logic      [1:0]                     s_bresp,
  input  wire logic                           s_arvalid,
  output logic                                s_arready,
  input  wire logic [csa_pkg::AXI_AW-1:0]     s_araddr,
  output logic                                s_rvalid,
  input  wire logic                           s_rready,
  output logic      [31:0]                    s_rdata,
  output logic      [1:0]                     s_rresp,
  // Instruction stream
  input  wire logic                           instr_valid,
  output logic                                instr_ready,
  input  wire logic [31:0]                    instr_word,
  input  wire logic [23:0]                    instr_ea,
  // General register read ports
  output logic      [2:0]                     gpr_sel_a,
  output logic      [2:0]                     gpr_sel_b,
  input  wire logic [31:0]                    gpr_data_a,
  input  wire logic [31:0]                    gpr_data_b,
  // Main memory word port
  output logic                                mem_req,
  output logic                                mem_we,
  output logic      [csa_pkg::MWA_W-1:0]      mem_addr,
  output logic      [csa_pkg::WORD_W-1:0]     mem_wdata,
  input  wire logic                           mem_ack,
  input  wire logic [csa_pkg::WORD_W-1:0]     mem_rdata,
  // Microcode entry
  output logic                                ucode_run,
  output logic      [csa_pkg::ENTRY_W-1:0]    ucode_entry,
  input  wire logic                           ucode_done,
  // Channel store operation
  output logic                                chan_req,
  output logic      [csa_pkg::CHA_W-1:0]      chan_addr,
  output logic      [3:0]                     chan_op,
  input  wire logic                           chan_ack,
  input  wire logic [3:0]                     chan_cc,
  // Completion
  output logic                                instr_done,
  output logic                                instr_trap,
  output logic                                cc_we,
  output logic      [3:0]                     cc_val
);
  csa_pkg::csa_state_e st_q, st_d;
  logic [csa_pkg::SA_W-1:0]    sa_q, sa_d;
  logic [csa_pkg::MWA_W-1:0]   ma_q, ma_d;
  logic [csa_pkg::ROW_W-1:0]   data_q, data_d, store_rdata;
  logic [csa_pkg::WORD_W-1:0]  wd_q, wd_d;
  logic [csa_pkg::ENTRY_W-1:0] ent_q, ent_d;
  logic [csa_pkg::CHA_W-1:0]   cha_q, cha_d;
  logic [3:0]                  chop_q, chop_d, cc_q, cc_d;
  logic                        trap_q, trap_d, ccwe_q, ccwe_d;
  logic [31:0]                 cnt_q, cnt_d;
  logic [1:0]                  ctrl;
  logic                        pres, two, acc, is_wr, is_rd, is_jmp, is_chan;
  logic                        bad_store, undef;
  logic [5:0]                  opc;
  logic [3:0]                  aug;
  logic [csa_pkg::CHA_W-1:0]   con;

  // Local names for the sequencer states keep the case items short and readable.
  localparam csa_pkg::csa_state_e S_IDLE = csa_pkg::S_IDLE;
  localparam csa_pkg::csa_state_e S_GET0 = csa_pkg::S_GET0;
  localparam csa_pkg::csa_state_e S_GET1 = csa_pkg::S_GET1;
  localparam csa_pkg::csa_state_e S_SWR  = csa_pkg::S_SWR;
  localparam csa_pkg::csa_state_e S_SRD  = csa_pkg::S_SRD;
  localparam csa_pkg::csa_state_e S_SLAT = csa_pkg::S_SLAT;
  localparam csa_pkg::csa_state_e S_PUT0 = csa_pkg::S_PUT0;
  localparam csa_pkg::csa_state_e S_PUT1 = csa_pkg::S_PUT1;
  localparam csa_pkg::csa_state_e S_UCOD = csa_pkg::S_UCOD;
  localparam csa_pkg::csa_state_e S_CHAN = csa_pkg::S_CHAN;
  localparam csa_pkg::csa_state_e S_FIN  = csa_pkg::S_FIN;

  // Field decode of the incoming 32-bit instruction word.
  assign opc       = instr_word[csa_pkg::OPC_HI:csa_pkg::OPC_LO];
  assign aug       = instr_word[csa_pkg::AUG_HI:csa_pkg::AUG_LO];
  assign con       = instr_word[csa_pkg::CON_HI:csa_pkg::CON_LO];
  assign gpr_sel_a = instr_word[csa_pkg::RD_HI:csa_pkg::RD_LO];
  assign gpr_sel_b = instr_word[csa_pkg::RS_HI:csa_pkg::RS_LO];
  assign is_wr     = (opc == csa_pkg::OPC_STORE) && (aug == csa_pkg::AUG_WRITE);
  assign is_rd     = (opc == csa_pkg::OPC_STORE) && (aug == csa_pkg::AUG_READ);
  assign is_jmp    = (opc == csa_pkg::OPC_JUMP);
  assign is_chan   = (opc == csa_pkg::OPC_CHAN);
  assign pres      = ctrl[csa_pkg::CTRL_PRES];
  assign two       = ctrl[csa_pkg::CTRL_TWO];
  assign acc       = instr_valid && instr_ready;

  // The location must be right-justified; any upper bit set counts as out of range.
  assign bad_store = (is_wr && csa_pkg::csa_store_bad(pres, two, gpr_data_a))
                  || (is_rd && csa_pkg::csa_store_bad(pres, two, gpr_data_b));
  assign undef     = bad_store || (is_jmp && !pres)
                  || !(is_wr || is_rd || is_jmp || is_chan);

  // Sequencer: every refused instruction goes straight to completion with a trap.
  always_comb begin
    st_d = st_q; sa_d = sa_q; ma_d = ma_q; data_d = data_q; wd_d = wd_q;
    ent_d = ent_q; cha_d = cha_q; chop_d = chop_q; trap_d = trap_q;
    ccwe_d = ccwe_q; cc_d = cc_q; cnt_d = cnt_q;
    case (st_q)
      S_IDLE: begin
        if (acc) begin
          trap_d = undef;
          ccwe_d = bad_store;
          cc_d   = bad_store ? csa_pkg::CC_ERR : csa_pkg::CC_NONE;
          sa_d   = is_wr ? gpr_data_a[csa_pkg::SA_W-1:0]
                         : gpr_data_b[csa_pkg::SA_W-1:0];
          ma_d   = is_wr ? gpr_data_b[csa_pkg::MWA_HI:csa_pkg::MWA_LO]
                         : gpr_data_a[csa_pkg::MWA_HI:csa_pkg::MWA_LO];
          ent_d  = instr_ea[csa_pkg::ENTRY_W-1:0];
          cha_d  = (gpr_sel_a == 3'h0) ? con : gpr_data_a[csa_pkg::CHA_W-1:0] + con;
          chop_d = instr_word[csa_pkg::CHOP_HI:csa_pkg::CHOP_LO];
          if (undef) st_d = S_FIN;
          else if (is_wr) st_d = S_GET0;
          else if (is_rd) st_d = S_SRD;
          else if (is_jmp) st_d = S_UCOD;
          else st_d = S_CHAN;
        end
      end
      S_GET0: begin
        if (mem_ack) begin
          data_d[csa_pkg::ROW_W-1:csa_pkg::WORD_W] = mem_rdata;
          ma_d = ma_q + 22'h1;
          st_d = S_GET1;
        end
      end
      S_GET1: begin
        if (mem_ack) begin
          data_d[csa_pkg::WORD_W-1:0] = mem_rdata;
          st_d = S_SWR;
        end
      end
      S_SWR: st_d = S_FIN;
      S_SRD: st_d = S_SLAT;
      S_SLAT: begin
        data_d = store_rdata;
        wd_d   = store_rdata[csa_pkg::ROW_W-1:csa_pkg::WORD_W];
        st_d   = S_PUT0;
      end
      S_PUT0: begin
        if (mem_ack) begin
          ma_d = ma_q + 22'h1;
          wd_d = data_q[csa_pkg::WORD_W-1:0];
          st_d = S_PUT1;
        end
      end
      S_PUT1: if (mem_ack) st_d = S_FIN;
      S_UCOD: if (ucode_done) st_d = S_FIN;
      S_CHAN: begin
        if (chan_ack) begin
          ccwe_d = 1'b1;
          cc_d   = chan_cc;
          st_d   = S_FIN;
        end
      end
      S_FIN: begin
        cnt_d = cnt_q + 32'h1;
        st_d  = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE; sa_q <= '0; ma_q <= '0; data_q <= '0; wd_q <= '0;
      ent_q <= '0; cha_q <= '0; chop_q <= '0; trap_q <= 1'b0;
      ccwe_q <= 1'b0; cc_q <= csa_pkg::CC_NONE; cnt_q <= '0;
    end else begin
      st_q <= st_d; sa_q <= sa_d; ma_q <= ma_d; data_q <= data_d; wd_q <= wd_d;
      ent_q <= ent_d; cha_q <= cha_d; chop_q <= chop_d; trap_q <= trap_d;
      ccwe_q <= ccwe_d; cc_q <= cc_d; cnt_q <= cnt_d;
    end
  end

  // Handshakes follow the state; data and addresses come from flops.
  assign instr_ready = (st_q == S_IDLE);
  assign mem_req     = (st_q == S_GET0) || (st_q == S_GET1)
                    || (st_q == S_PUT0) || (st_q == S_PUT1);
  assign mem_we      = (st_q == S_PUT0) || (st_q == S_PUT1);
  assign mem_addr    = ma_q;
  assign mem_wdata   = wd_q;
  assign ucode_run   = (st_q == S_UCOD);
  assign ucode_entry = ent_q;
  assign chan_req    = (st_q == S_CHAN);
  assign chan_addr   = cha_q;
  assign chan_op     = chop_q;
  assign instr_done  = (st_q == S_FIN);
  assign instr_trap  = trap_q && instr_done;
  assign cc_we       = ccwe_q && instr_done;
  assign cc_val      = cc_q;

  csa_store u_store (
    .aclk  (aclk),
    .we    (st_q == S_SWR),
    .re    (st_q == S_SRD),
    .addr  (sa_q),
    .wdata (data_q),
    .rdata (store_rdata)
  );

  csa_axil u_regs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (s_awvalid),
    .awready (s_awready),
    .awaddr  (s_awaddr),
    .wvalid  (s_wvalid),
    .wready  (s_wready),
    .wdata   (s_wdata),
    .wstrb   (s_wstrb),
    .bvalid  (s_bvalid),
    .bready  (s_bready),
    .bresp   (s_bresp),
    .arvalid (s_arvalid),
    .arready (s_arready),
    .araddr  (s_araddr),
    .rvalid  (s_rvalid),
    .rready  (s_rready),
    .rdata   (s_rdata),
    .rresp   (s_rresp),
    .ctrl    (ctrl),
    .stat    ({18'h0, ent_q, 6'h0, trap_q, (st_q != S_IDLE)}),
    .count   (cnt_q)
  );

  // Checks on the sequencer; all sample on the clock and pause in reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_bad_write;
    acc && is_wr && bad_store |=> instr_done && instr_trap && cc_we && cc_val == 4'h8
      ##1 !mem_req && st_q == S_IDLE;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("Bad write not trapped.");

  property p_bad_read;
    acc && is_rd && bad_store |=> instr_trap && cc_val == 4'h8 ##1 !mem_we;
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("Bad read not trapped.");

  property p_write_addr;
    acc && is_wr && !undef |=> mem_req && !mem_we && mem_addr == $past(gpr_data_b[23:2]);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("Wrong source address.");

  property p_ascending;
    mem_req && mem_ack && (st_q == S_GET0 || st_q == S_PUT0) |=> mem_addr == $past(mem_addr) + 22'h1;
  endproperty
  a_ascending: assert property (p_ascending) else $error("Second word not next address.");

  property p_low_word;
    st_q == S_GET1 && mem_ack |=> data_q[31:0] == $past(mem_rdata) ##1 instr_done;
  endproperty
  a_low_word: assert property (p_low_word) else $error("Store row not assembled.");

  property p_jump_entry;
    acc && is_jmp && pres |=> ucode_run && ucode_entry == $past(instr_ea[5:0]);
  endproperty
  a_jump_entry: assert property (p_jump_entry) else $error("Wrong microcode entry.");

  property p_jump_return;
    ucode_run && ucode_done |=> instr_done && !instr_trap && !cc_we;
  endproperty
  a_jump_return: assert property (p_jump_return) else $error("Jump did not resume.");

  property p_jump_absent;
    acc && is_jmp && !pres |=> instr_done && instr_trap && !ucode_run;
  endproperty
  a_jump_absent: assert property (p_jump_absent) else $error("Absent store jump not trapped.");

  property p_chan_addr;
    acc && is_chan |=> chan_req && chan_addr == ($past(gpr_sel_a) == 3'h0 ? $past(con)
                       : $past(gpr_data_a[15:0]) + $past(con));
  endproperty
  a_chan_addr: assert property (p_chan_addr) else $error("Wrong channel address.");

  property p_read_upper;
    st_q == S_SLAT |=> mem_req && mem_we && mem_wdata == $past(store_rdata[63:32]);
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("Read upper word not first.");

  property p_chan_cc;
    chan_req && chan_ack |=> instr_done && cc_we && cc_val == $past(chan_cc);
  endproperty
  a_chan_cc: assert property (p_chan_cc) else $error("Channel condition code lost.");

  c_write: cover property (st_q == S_SWR ##1 instr_done);
  c_read:  cover property (st_q == S_PUT1 && mem_ack ##1 instr_done);
  c_jump:  cover property (ucode_run && ucode_done ##1 instr_done);
  c_chan:  cover property (chan_req && chan_ack ##1 instr_done);
endmodule : csa_core

// ### dv/csa_mem_model.sv
// Purpose: Main memory, microcode and channel partner for the core.
// Assumes: One request at a time, held until it is acknowledged.
// Notes:   Idle read data toggles every cycle so a stale word never matches.
`timescale 1ns/10ps
module csa_mem_model (
  // Clock
  input  wire logic        aclk,
  // Memory word port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [21:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  // Microcode and channel
  input  wire logic        ucode_run,
  output logic             ucode_done,
  input  wire logic        chan_req,
  output logic             chan_ack
);
  logic [31:0] mem [16];
  logic [2:0]  uc;
  logic [21:0] seq [$];
  // Each word is preset to a distinct value.
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = ~i;
    {mem_ack, ucode_done, chan_ack, uc, mem_rdata} = '0;
  end
  // Words answer one cycle late, so a design that drops its request early fails.
  always @(posedge aclk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      seq.push_back(mem_addr);
      if (mem_we) mem[mem_addr[3:0]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[3:0]];
    end
    uc <= ucode_run ? uc + 3'h1 : 3'h0;
    ucode_done <= ucode_run && uc == 3'h3;
    chan_ack <= chan_req && !chan_ack;
  end
endmodule : csa_mem_model

// ### dv/tb_top.sv
// Purpose: Self-checking bench for the store access core.
// Assumes: Register 1 holds store location 5, registers 2 and 3 memory addresses.
// Notes:   Registers 4 and 5 hold locations 4096 and 2048, past two and one modules.
`timescale 1ns/10ps
module tb_top;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, instr_valid, instr_ready, mem_req;
  logic mem_we, mem_ack, ucode_run, ucode_done, chan_req, chan_ack, instr_done;
  logic instr_trap, cc_we, tr, cw;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, instr_word, gpr_data_a, gpr_data_b, mem_wdata, mem_rdata;
  logic [3:0]  s_wstrb, chan_op, chan_cc, cc_val, cv;
  logic [1:0]  s_bresp, s_rresp;
  logic [23:0] instr_ea;
  logic [2:0]  gpr_sel_a, gpr_sel_b;
  logic [21:0] mem_addr;
  logic [5:0]  ucode_entry;
  logic [15:0] chan_addr;
  logic [31:0] gpr [8] = '{0, 5, 32'h13, 32'h20, 32'h1000, 32'h800, 0, 0};
  int          n_errors, checks_done;
  csa_core uut (.*);
  csa_mem_model pm (.*);
  // Register file answers its selectors in the same cycle.
  assign gpr_data_a = gpr[gpr_sel_a];
  assign gpr_data_b = gpr[gpr_sel_b];
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task chk(input logic c);
    checks_done++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: compare failed", $time);
    end
  endtask : chk
  // Offers one instruction and waits for its completion pulse.
  task ex(input logic [31:0] w, input logic [23:0] e);
    @(posedge aclk);
    pm.seq.delete();
    instr_valid <= 1; instr_word <= w; instr_ea <= e;
    do @(negedge aclk); while (instr_ready !== 1'b1);
    @(posedge aclk);
    instr_valid <= 0;
    do @(negedge aclk); while (instr_done !== 1'b1);
    tr = instr_trap; cw = cc_we; cv = cc_val;
  endtask : ex
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw;
    ka = 0; kw = 0;
    @(posedge aclk);
    s_awvalid <= 1; s_awaddr <= a; s_wvalid <= 1; s_wdata <= d; s_bready <= 1;
    do begin
      @(negedge aclk); ka |= s_awready; kw |= s_wready;
      @(posedge aclk); if (ka) s_awvalid <= 0; if (kw) s_wvalid <= 0;
    end while (!(ka && kw));
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    chk(s_bresp === 2'h0);
    @(posedge aclk); s_bready <= 0;
  endtask : axw
  task axr(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    @(posedge aclk); s_arvalid <= 1; s_araddr <= a; s_rready <= 1;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk); s_arvalid <= 0;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    chk(s_rresp === r && s_rdata === d);
    @(posedge aclk); s_rready <= 0;
  endtask : axr
  task t_xfer;
    ex(32'h00aa0000, 0);
    chk(tr === 0 && cw === 0 && pm.seq.size() == 2 && pm.seq[0] === 4 && pm.seq[1] === 5);
    ex(32'h019b0000, 0);
    chk(tr === 0 && cw === 0 && pm.mem[8] === ~32'd4 && pm.mem[9] === ~32'd5);
  endtask : t_xfer
  task t_bad;
    ex(32'h022a0000, 0);
    chk(tr === 1 && cw === 1 && cv === 4'h8 && pm.seq.size() == 0);
    ex(32'h04000000, 0);
    chk(tr === 1 && cw === 0 && pm.seq.size() == 0);
    ex(32'h01cb0000, 0);
    chk(tr === 1 && cw === 1 && cv === 4'h8 && pm.seq.size() == 0);
  endtask : t_bad
  task t_jump_chan;
    ex(32'hf8000000, 24'h1234a7);
    chk(tr === 0 && cw === 0 && ucode_entry === 6'h27);
    axr(8'h04, 2'h0, 32'h00002700);
    ex(32'hf4a80100, 0);
    chk(cw === 1 && cv === 4'h6 && chan_addr === 16'h0105 && chan_op === 4'h5);
    ex(32'hf4280100, 0);
    chk(tr === 0 && cw === 1 && chan_addr === 16'h0100);
  endtask : t_jump_chan
  task t_off;
    axr(8'h00, 2'h0, 32'h3);
    axw(8'h00, 32'h1);
    ex(32'h02aa0000, 0);
    chk(tr === 1 && cw === 1 && cv === 4'h8 && pm.seq.size() == 0);
    axw(8'h00, 32'h0);
    ex(32'hf8000000, 0);
    chk(tr === 1 && cw === 0);
    ex(32'h019b0000, 0);
    chk(tr === 1 && cv === 4'h8 && pm.seq.size() == 0);
    axr(8'h40, 2'h2, 32'h0);
  endtask : t_off
  // Inputs start quiet; reset is held for eight cycles.
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, instr_valid} = '0;
    {s_awaddr, s_araddr, s_wdata, instr_word, instr_ea} = '0;
    s_wstrb = 4'hf;
    chan_cc = 4'h6;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_xfer;
    t_bad;
    t_jump_chan;
    t_off;
    report_and_stop;
  end
  // The whole run needs under a hundred cycles; this limit is 5000 cycles, over fifty times that.
  initial begin
    #20000;
    n_errors++;
    report_and_stop;
  end
endmodule : tb_top
